// [tcn_regs.svh]
/*
 * register offsets, field positions, reset values and fixed-point constants
 * of the torque conditioning block. assumes 32-bit register words on an 8-bit
 * byte address, and a 25 MHz core clock.
 */
`ifndef TCN_REGS_SVH
`define TCN_REGS_SVH

`define ADDR_COULOMB     8'h00
`define ADDR_DEAD_BAND   8'h04
`define ADDR_VISCOUS     8'h08
`define ADDR_LOAD_PCT    8'h0C
`define ADDR_OBS_GAIN    8'h10
`define ADDR_MF_CFG      8'h14
`define ADDR_MF_GAIN     8'h18
`define ADDR_MF_DAMP     8'h1C
`define ADDR_MF_SPD_FF   8'h20
`define ADDR_MF_TRQ_FF   8'h24
`define ADDR_NOTCH_A     8'h28
`define ADDR_CTRL        8'h34
`define ADDR_STATUS      8'h38
`define ADDR_TRQ_OUT     8'h3C
`define NOTCH_STRIDE     4

`define MFC_SEL_R        1:0
`define MFC_SPD_SRC_R    5:4
`define MFC_TRQ_SRC_R    7:6
`define MFC_POS_MODE_B   8
`define MFC_MANUAL_B     9
`define MFC_FULL_CL_B    10
`define NC_FREQ_R        15:0
`define NC_DEPTH_R       20:16
`define NC_WIDTH_R       27:24
`define CTRL_RESTART_B   0

`define NOTCH_OFF_FREQ   16'h1388
`define DEPTH_MAX        5'h17
`define PCT_RST          16'h0064

`define CLK_HZ           25000000
`define CTRL_HZ          10000
`define CTRL_DIV         12'((`CLK_HZ) / (`CTRL_HZ))

`define DIV100_MUL       64'sh0029
`define DIV100_SH        12
`define FREQ_K           64'sh000A
`define F_MAX            64'sh2EE0
`define Q_SH             14
`define Q_UNIT_SH        11
`define DEPTH_INV        64'sh0059
`define DEPTH_SH         11
`define VISC_SH          8
`define OBS_SH           16
`define MF_GAIN_SH       12
`define MF_DAMP_SH       8

`endif

// [tcn_pkg.sv]
/*
 * types shared by the torque conditioning block and its sub-modules.
 * assumes nothing of its surroundings.
 */
package tcn_pkg;

    typedef logic signed [15:0] trq_t;

    typedef enum logic [1:0] {MF_OFF = 2'h0, MF_ON = 2'h1, MF_ON_LOS = 2'h2} mf_sel_t;

    typedef enum logic [1:0] {FF_INTERNAL = 2'h0, FF_MODEL = 2'h1, FF_HOST = 2'h2, FF_CUBIC = 2'h3} ff_src_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [4:0]  depth;
        logic [3:0]  width;
    } notch_cfg_t;

    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] damp;
        logic [15:0] spd_pct;
        logic [15:0] trq_pct;
    } mf_cfg_t;

    typedef struct packed {
        logic signed [31:0] pos;
        logic signed [31:0] spd;
        trq_t               trq;
    } mf_out_t;

    function automatic trq_t sat16(input logic signed [63:0] v);
        if (v[63:15] != {49{v[63]}}) begin
            return v[63] ? 16'sh8000 : 16'sh7FFF;
        end
        return v[15:0];
    endfunction

endpackage

// [notch_stage.sv]
/*
 * one notch stage: state-variable filter, band part removed by depth.
 * assumes tick_i is a one-cycle control-rate pulse on core_clk_i.
 */
`timescale 1ns/1ps
`include "tcn_regs.svh"
module notch_stage
    import tcn_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       tick_i,
    input  wire trq_t       x_i,
    input  wire notch_cfg_t cfg_i,
    output trq_t            y_o
);
    typedef struct packed {
        logic signed [31:0] lp;
        logic signed [31:0] bp;
        trq_t               y;
    } notch_st_t;

    notch_st_t          s;
    notch_st_t          n;
    logic signed [63:0] f;
    logic signed [63:0] q;
    logic signed [63:0] hp;
    logic signed [63:0] qbp;
    logic signed [63:0] dg;

    always_comb begin
        n   = s;
        f   = {48'h0, cfg_i.freq} * `FREQ_K;            // RL16
        if (f > `F_MAX) begin
            f = `F_MAX;
        end
        q   = ({60'h0, cfg_i.width} + 64'sh0001) <<< `Q_UNIT_SH;
        dg  = {59'h0, 5'(`DEPTH_MAX - cfg_i.depth)};
        qbp = (q * 64'(s.bp)) >>> `Q_SH;
        hp  = 64'(x_i) - 64'(s.lp) - qbp;
        if (tick_i) begin
            if (cfg_i.freq == `NOTCH_OFF_FREQ) begin
                n.lp = '0;                               // RL17
                n.bp = '0;
                n.y  = x_i;
            end else begin
                n.lp = 32'(64'(s.lp) + ((f * 64'(s.bp)) >>> `Q_SH));
                n.bp = 32'(64'(s.bp) + ((f * hp) >>> `Q_SH));
                n.y  = sat16(64'(x_i) - (((qbp * dg) * `DEPTH_INV) >>> `DEPTH_SH)); // RL16
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign y_o = s.y;

    AST_NOTCH_OFF: assert property (@(posedge core_clk_i) disable iff (reset_i) // RL17
        tick_i && cfg_i.freq == `NOTCH_OFF_FREQ |=> y_o == $past(x_i))
        else $error("disabled notch altered the torque reference");
endmodule

// [model_follow.sv]
/*
 * model following generator: second-order motor model tracking the position
 * reference, giving corrected position and scaled speed/torque feedforward.
 * assumes tick_i is a one-cycle control-rate pulse on core_clk_i.
 */
`timescale 1ns/1ps
`include "tcn_regs.svh"
module model_follow
    import tcn_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire logic               tick_i,
    input  wire logic               en_i,
    input  wire logic signed [31:0] pos_ref_i,
    input  wire mf_cfg_t            cfg_i,
    output mf_out_t                 out_o
);
    typedef struct packed {
        logic signed [31:0] pm;
        logic signed [31:0] vm;
        mf_out_t            o;
    } mf_st_t;

    mf_st_t             s;
    mf_st_t             n;
    logic signed [63:0] err;
    logic signed [63:0] acc;
    logic signed [63:0] vn;

    always_comb begin
        n   = s;
        err = 64'(pos_ref_i) - 64'(s.pm);
        acc = ((err * $signed({48'h0, cfg_i.gain})) >>> `MF_GAIN_SH)     // RL9
            - ((64'(s.vm) * $signed({48'h0, cfg_i.damp})) >>> `MF_DAMP_SH); // RL10
        vn  = 64'(s.vm) + acc;
        if (tick_i) begin
            if (!en_i) begin
                n.pm = pos_ref_i;
                n.vm = '0;
                n.o  = '{pos: pos_ref_i, spd: '0, trq: '0};
            end else begin
                n.vm    = 32'(vn);                                        // RL8
                n.pm    = 32'(64'(s.pm) + vn);
                n.o.pos = 32'(64'(s.pm) + vn);
                n.o.spd = 32'((vn * $signed({48'h0, cfg_i.spd_pct}) * `DIV100_MUL) >>> `DIV100_SH); // RL11
                n.o.trq = sat16((acc * $signed({48'h0, cfg_i.trq_pct}) * `DIV100_MUL) >>> `DIV100_SH);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign out_o = s.o;
endmodule

// [torque_compensation_and_notch.sv]
/*
 * torque reference conditioning: friction and load compensation, model
 * following generator, three cascaded notch filters, register port.
 * assumes all inputs come from logic on core_clk_i and that the register
 * master keeps strobes one cycle long and never both at once.
 */
// Notes on behaviour
// RL1 - coulomb compensation takes the sign of the present motor speed
// RL2 - speed inside the dead band gives zero coulomb compensation
// RL3 - viscous compensation is speed times the viscous coefficient
// RL4 - load torque compensation is added into the torque reference
// RL5 - load compensation is observer estimate times the load percentage
// RL6 - observer gain sets how closely the estimate tracks load torque
// RL7 - model select 0 off, 1 on, 2 on with oscillation suppression (the code runs 2 the same as 1, with no suppression); after restart
// RL8 - model generates corrected position plus speed and torque feedforward
// RL9 - model gain sets position response speed
// RL10 - model damping setting sets the damping ratio
// RL11 - model speed and torque feedforward each scaled by own percentage
// RL12 - feedforward scaling matters only when the source select is 1
// RL13 - model following only in position mode with manual tuning
// RL14 - model following unavailable under fully closed loop
// RL15 - three notch filters, individually enabled, cascaded on torque path
// RL16 - each notch has own centre frequency, depth and width
// RL17 - notch frequency 5000 means disabled, passes torque unchanged
// RL18 - notch depth accepts 0 through 23
// RL19 - notch width accepts 0 through 15
// RL20 - feedforward source 1 picks the model feedforward over internal
// RL21 - compensation summed into torque before the notches every control cycle
// RL22 - tuning settings act on the next control cycle without restart
`timescale 1ns/1ps
`include "tcn_regs.svh"
module torque_compensation_and_notch
    import tcn_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [31:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [31:0]        reg_rdata_o,
    input  wire trq_t               speed_i,
    input  wire logic signed [31:0] pos_ref_i,
    input  wire trq_t               obs_torque_i,
    input  wire trq_t               torque_ref_i,
    input  wire logic signed [31:0] int_speed_ff_i,
    input  wire trq_t               int_torque_ff_i,
    output trq_t                    torque_ref_o,
    output logic signed [31:0]      pos_ref_o,
    output logic signed [31:0]      speed_ff_o,
    output logic                    mf_active_o,
    output logic                    ctrl_tick_o
);
    typedef struct packed {
        logic [11:0]        div;
        logic               tick;
        logic [15:0]        coul_lvl;
        logic [15:0]        dead_band;
        logic [15:0]        visc;
        logic [15:0]        load_pct;
        logic [15:0]        obs_gain;
        mf_sel_t            sel_pend;
        ff_src_t            spd_src_pend;
        ff_src_t            trq_src_pend;
        mf_sel_t            sel_act;
        ff_src_t            spd_src_act;
        ff_src_t            trq_src_act;
        logic               pos_mode;
        logic               manual;
        logic               full_closed;
        logic               mf_active;
        mf_cfg_t            mf;
        notch_cfg_t [2:0]   nc;
        logic signed [31:0] obs_est;
        trq_t               coul;
        trq_t               visct;
        trq_t               load;
        trq_t               tff;
        trq_t               sum;
        trq_t               trq_out;
        logic signed [31:0] pos_out;
        logic signed [31:0] spd_out;
        logic [31:0]        rdata;
    } main_st_t;

    main_st_t           s;
    main_st_t           n;
    mf_out_t            mf_o;
    trq_t               chain [0:3];
    logic signed [16:0] spd_mag;
    logic               in_band;
    logic signed [63:0] est_n;
    logic signed [63:0] visc_p;
    logic [4:0]         depth_w;
    trq_t               coul_n;
    trq_t               visc_n;
    trq_t               load_n;
    trq_t               tff_n;

    always_comb begin
        n       = s;
        n.rdata = '0;
        n.tick  = 1'b0;
        if (s.div == `CTRL_DIV - 12'h001) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 12'h001;
        end

        // register writes
        depth_w = reg_wdata_i[`NC_DEPTH_R];
        if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_COULOMB:   n.coul_lvl    = reg_wdata_i[15:0];     // RL22
                `ADDR_DEAD_BAND: n.dead_band   = reg_wdata_i[15:0];
                `ADDR_VISCOUS:   n.visc        = reg_wdata_i[15:0];
                `ADDR_LOAD_PCT:  n.load_pct    = reg_wdata_i[15:0];
                `ADDR_OBS_GAIN:  n.obs_gain    = reg_wdata_i[15:0];
                `ADDR_MF_GAIN:   n.mf.gain     = reg_wdata_i[15:0];
                `ADDR_MF_DAMP:   n.mf.damp     = reg_wdata_i[15:0];
                `ADDR_MF_SPD_FF: n.mf.spd_pct  = reg_wdata_i[15:0];
                `ADDR_MF_TRQ_FF: n.mf.trq_pct  = reg_wdata_i[15:0];
                `ADDR_MF_CFG: begin
                    n.sel_pend     = mf_sel_t'(reg_wdata_i[`MFC_SEL_R]);
                    n.spd_src_pend = ff_src_t'(reg_wdata_i[`MFC_SPD_SRC_R]);
                    n.trq_src_pend = ff_src_t'(reg_wdata_i[`MFC_TRQ_SRC_R]);
                    n.pos_mode     = reg_wdata_i[`MFC_POS_MODE_B];
                    n.manual       = reg_wdata_i[`MFC_MANUAL_B];
                    n.full_closed  = reg_wdata_i[`MFC_FULL_CL_B];
                end
                `ADDR_CTRL: begin
                    if (reg_wdata_i[`CTRL_RESTART_B]) begin
                        n.sel_act     = s.sel_pend;                     // RL7
                        n.spd_src_act = s.spd_src_pend;
                        n.trq_src_act = s.trq_src_pend;
                    end
                end
                default: ;
            endcase
            for (int i = 0; i < 3; i++) begin
                if (reg_addr_i == 8'(`ADDR_NOTCH_A + `NOTCH_STRIDE * i)) begin
                    n.nc[i].freq  = reg_wdata_i[`NC_FREQ_R];
                    n.nc[i].depth = (depth_w > `DEPTH_MAX) ? `DEPTH_MAX : depth_w; // RL18
                    n.nc[i].width = reg_wdata_i[`NC_WIDTH_R];            // RL19
                end
            end
        end

        // register reads, zero for unmapped offsets
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_COULOMB:   n.rdata = {16'h0, s.coul_lvl};
                `ADDR_DEAD_BAND: n.rdata = {16'h0, s.dead_band};
                `ADDR_VISCOUS:   n.rdata = {16'h0, s.visc};
                `ADDR_LOAD_PCT:  n.rdata = {16'h0, s.load_pct};
                `ADDR_OBS_GAIN:  n.rdata = {16'h0, s.obs_gain};
                `ADDR_MF_GAIN:   n.rdata = {16'h0, s.mf.gain};
                `ADDR_MF_DAMP:   n.rdata = {16'h0, s.mf.damp};
                `ADDR_MF_SPD_FF: n.rdata = {16'h0, s.mf.spd_pct};
                `ADDR_MF_TRQ_FF: n.rdata = {16'h0, s.mf.trq_pct};
                `ADDR_MF_CFG:    n.rdata = {21'h0, s.full_closed, s.manual, s.pos_mode,
                                            s.trq_src_pend, s.spd_src_pend, 2'h0, s.sel_pend};
                `ADDR_STATUS:    n.rdata = {25'h0, s.mf_active, s.trq_src_act, s.spd_src_act, s.sel_act};
                `ADDR_TRQ_OUT:   n.rdata = {{16{s.trq_out[15]}}, s.trq_out};
                default:         n.rdata = '0;
            endcase
            for (int i = 0; i < 3; i++) begin
                if (reg_addr_i == 8'(`ADDR_NOTCH_A + `NOTCH_STRIDE * i)) begin
                    n.rdata = {4'h0, s.nc[i].width, 3'h0, s.nc[i].depth, s.nc[i].freq};
                end
            end
        end

        n.mf_active = (s.sel_act == MF_ON || s.sel_act == MF_ON_LOS)
                    && s.pos_mode && s.manual                            // RL13
                    && !s.full_closed;                                   // RL14

        // compensation terms, evaluated once per control cycle
        spd_mag = speed_i[15] ? -{1'b1, speed_i} : {1'b0, speed_i};
        in_band = $unsigned(spd_mag) <= {1'b0, s.dead_band};
        coul_n  = in_band ? '0 :                                         // RL2
                  speed_i[15] ? sat16(-{48'h0, s.coul_lvl}) : sat16({48'h0, s.coul_lvl}); // RL1
        visc_p  = 64'(speed_i) * {48'h0, s.visc};
        visc_n  = sat16(visc_p >>> `VISC_SH);                            // RL3
        est_n   = 64'(s.obs_est)
                + (((64'(obs_torque_i) - 64'(s.obs_est)) * $signed({48'h0, s.obs_gain})) >>> `OBS_SH); // RL6
        load_n  = sat16((est_n * $signed({48'h0, s.load_pct}) * `DIV100_MUL) >>> `DIV100_SH); // RL5
        tff_n   = (s.mf_active && s.trq_src_act == FF_MODEL) ? mf_o.trq : int_torque_ff_i; // RL12 RL20
        if (s.tick) begin
            n.obs_est = 32'(est_n);
            n.coul    = coul_n;
            n.visct   = visc_n;
            n.load    = load_n;
            n.tff     = tff_n;
            n.sum     = sat16(64'(torque_ref_i) + 64'(coul_n) + 64'(visc_n)
                            + 64'(load_n) + 64'(tff_n));                 // RL4 RL21
            n.trq_out = chain[3];
            n.pos_out = s.mf_active ? mf_o.pos : pos_ref_i;              // RL8
            n.spd_out = (s.mf_active && s.spd_src_act == FF_MODEL) ? mf_o.spd : int_speed_ff_i; // RL20
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s             <= '0;
            s.mf.spd_pct  <= `PCT_RST;
            s.mf.trq_pct  <= `PCT_RST;
            for (int i = 0; i < 3; i++) begin
                s.nc[i].freq <= `NOTCH_OFF_FREQ;
            end
        end else begin
            s <= n;
        end
    end

    model_follow u_model (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .tick_i     (s.tick),
        .en_i       (s.mf_active),
        .pos_ref_i  (pos_ref_i),
        .cfg_i      (s.mf),
        .out_o      (mf_o)
    );

    assign chain[0] = s.sum;

    // notch cascade on the summed torque reference
    for (genvar g = 0; g < 3; g++) begin : g_notch
        notch_stage u_notch (                                            // RL15
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .tick_i     (s.tick),
            .x_i        (chain[g]),
            .cfg_i      (s.nc[g]),
            .y_o        (chain[g+1])
        );
    end

    assign reg_rdata_o  = s.rdata;
    assign torque_ref_o = s.trq_out;
    assign pos_ref_o    = s.pos_out;
    assign speed_ff_o   = s.spd_out;
    assign mf_active_o  = s.mf_active;
    assign ctrl_tick_o  = s.tick;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_restart;
        reg_wr_i && reg_addr_i == `ADDR_CTRL && reg_wdata_i[`CTRL_RESTART_B];
    endsequence

    sequence s_model_trq_tick;
        s.tick && s.mf_active && s.trq_src_act == FF_MODEL;
    endsequence

    AST_COUL_DEAD: assert property (s.tick && in_band |=> s.coul == '0) // RL2
        else $error("coulomb term nonzero inside dead band");

    AST_COUL_SIGN: assert property (s.tick && !in_band |=>                // RL1
        ($past(speed_i[15]) ? (s.coul <= 0) : (s.coul >= 0)))
        else $error("coulomb term sign differs from speed sign");

    AST_VISC_ZERO: assert property (s.tick && (speed_i == '0 || s.visc == '0) |=> s.visct == '0) // RL3
        else $error("viscous term nonzero at zero speed or coefficient");

    AST_LOAD_ZERO: assert property (s.tick && s.load_pct == '0 |=> s.load == '0) // RL5
        else $error("load term nonzero with zero percentage");

    AST_SUM: assert property (s.tick |=> s.sum == sat16(64'($past(torque_ref_i)) + 64'(s.coul) // RL21
        + 64'(s.visct) + 64'(s.load) + 64'(s.tff)))
        else $error("torque sum does not match its terms");

    AST_SEL_APPLY: assert property (s_restart |=> s.sel_act == $past(s.sel_pend)) // RL7
        else $error("restart did not apply model select");

    AST_SEL_HOLD: assert property (!reg_wr_i |=> $stable(s.sel_act) && $stable(s.trq_src_act)) // RL7
        else $error("model select changed without restart");

    AST_FULL_CLOSED: assert property (s.full_closed |=> !mf_active_o) // RL14
        else $error("model following active in fully closed loop");

    AST_POS_MANUAL: assert property (!s.pos_mode || !s.manual |=> !mf_active_o) // RL13
        else $error("model following active outside position manual tuning");

    AST_POS_PASS: assert property (s.tick && !s.mf_active |=> pos_ref_o == $past(pos_ref_i)) // RL8
        else $error("position reference altered with model off");

    AST_FF_MODEL: assert property (s_model_trq_tick |=> s.tff == $past(mf_o.trq)) // RL20
        else $error("model torque feedforward not selected");

    AST_FF_INTERNAL: assert property (s.tick && s.trq_src_act != FF_MODEL |=> // RL12
        s.tff == $past(int_torque_ff_i))
        else $error("internal torque feedforward not used");

    AST_DEPTH: assert property (reg_wr_i && reg_addr_i == `ADDR_NOTCH_A // RL18
        && reg_wdata_i[`NC_DEPTH_R] > `DEPTH_MAX |=> s.nc[0].depth == `DEPTH_MAX)
        else $error("notch depth above range not clamped");
endmodule

// [motor_fb.sv]
/*
 * partner model: encoder speed feedback and load torque observer source.
 * assumes the block's control tick on the same core clock.
 */
`timescale 1ns/1ps
module motor_fb
    import tcn_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic tick_i,
    input  wire trq_t speed_set_i,
    input  wire trq_t load_i,
    output trq_t      speed_o,
    output trq_t      obs_torque_o
);
    trq_t spd = '0;
    trq_t obs = '0;
    // new samples only at the control tick, like an encoder update
    always @(posedge core_clk_i) begin
        if (tick_i) begin
            spd <= speed_set_i;
            obs <= load_i;
        end
    end
    assign speed_o      = spd;
    assign obs_torque_o = obs;
endmodule

// [torque_compensation_and_notch_tb.sv]
/*
 * self-checking bench of the torque conditioning block.
 * assumes the design files and motor_fb are compiled first.
 */
`timescale 1ns/1ps
module torque_compensation_and_notch_tb;
    import tcn_pkg::*;
    logic              core_clk, reset, wr, rd, mfa, tick;
    logic [7:0]        addr;
    logic [31:0]       wdata, rdata, v;
    trq_t              speed, obs, tref, itff, tout, spd_set, load;
    logic signed [31:0] pref, isff, pout, sffo;
    int                num_errors = 0;
    int                compares = 0;

    torque_compensation_and_notch dut (.core_clk_i(core_clk), .reset_i(reset), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .speed_i(speed),
        .pos_ref_i(pref), .obs_torque_i(obs), .torque_ref_i(tref), .int_speed_ff_i(isff),
        .int_torque_ff_i(itff), .torque_ref_o(tout), .pos_ref_o(pout), .speed_ff_o(sffo),
        .mf_active_o(mfa), .ctrl_tick_o(tick));
    motor_fb fb (.core_clk_i(core_clk), .tick_i(tick), .speed_set_i(spd_set), .load_i(load),
        .speed_o(speed), .obs_torque_o(obs));

    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1;
        @(posedge core_clk);
        wr <= 0;
    endtask

    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1;
        @(posedge core_clk);
        rd <= 0;
        #1 d = rdata;
    endtask

    // waits for n control ticks, bounded
    task ticks(input int n);
        int k;
        k = 0;
        repeat (n) begin
            do begin
                @(posedge core_clk);
                k++;
                if (k > 3000 * n) begin
                    num_errors++;
                    results();
                end
            end while (tick !== 1'b1);
        end
        #1;
    endtask

    task t_regs;
        rd_reg(8'h20, v); check("spd_pct", v, 32'h0000_0064);
        rd_reg(8'h24, v); check("trq_pct", v, 32'h0000_0064);
        rd_reg(8'h28, v); check("notch_a", v, 32'h0000_1388);
        rd_reg(8'h30, v); check("notch_c", v, 32'h0000_1388);
        rd_reg(8'h40, v); check("unmapped", v, 32'h0000_0000);
        wr_reg(8'h2C, 32'h0F1F_1388);
        rd_reg(8'h2C, v); check("depth_clamp", v, 32'h0F17_1388);
        wr_reg(8'h2C, 32'h0F00_1388);
        rd_reg(8'h2C, v); check("width_max", v, 32'h0F00_1388);
    endtask

    // coulomb 50, band 10, viscous 2.0, observer frozen at zero
    task t_fric;
        trq_t sp [6] = '{16'sd5, 16'sd10, 16'sd11, -16'sd11, -16'sd100, 16'sd20000};
        trq_t ex [6] = '{16'sd1010, 16'sd1020, 16'sd1072, 16'sd928, 16'sd750, 16'sh7FFF};
        wr_reg(8'h00, 32'h0000_0032);
        wr_reg(8'h04, 32'h0000_000A);
        wr_reg(8'h08, 32'h0000_0200);
        wr_reg(8'h0C, 32'h0000_0064);
        wr_reg(8'h10, 32'h0000_0000);
        tref <= 16'sd1000;
        load <= 16'sd2000;
        for (int i = 0; i < 6; i++) begin
            spd_set <= sp[i];
            ticks(7);
            check("torque_out", 32'(tout), 32'(ex[i]));
        end
        rd_reg(8'h3C, v); check("trq_reg", v, 32'h0000_7FFF);
    endtask

    // model off: speed source 1 refused, internal torque ff and half load summed
    task t_ff;
        pref <= 32'h0001_2345;
        isff <= 32'h0000_0777;
        itff <= -16'sd300;
        spd_set <= 16'sd0;
        wr_reg(8'h10, 32'h0000_FFFF);
        wr_reg(8'h0C, 32'h0000_0032);
        wr_reg(8'h14, 32'h0000_0010);
        wr_reg(8'h34, 32'h0000_0001);
        ticks(7);
        check("pos_ref", pout, 32'h0001_2345);
        check("spd_ff", sffo, 32'h0000_0777);
        check("trq_ff", 32'(tout), 32'(16'sd1700));
    endtask

    // model on: gain 1.0, damping 1.0 settles a step in one tick
    task t_model;
        wr_reg(8'h0C, 32'h0000_0000);
        wr_reg(8'h18, 32'h0000_1000);
        wr_reg(8'h1C, 32'h0000_0100);
        wr_reg(8'h14, 32'h0000_0351);
        wr_reg(8'h34, 32'h0000_0001);
        ticks(3);
        pref <= 32'h0001_3345;
        ticks(2);
        check("mf_pos", pout, 32'h0001_3345);
        check("mf_spd_ff", sffo, 32'h0000_1004);
        ticks(6);
        check("mf_spd_done", sffo, 32'h0000_0000);
        check("mf_trq_ff", 32'(tout), 32'(16'sd1000));
        wr_reg(8'h14, 32'h0000_0000);
        wr_reg(8'h34, 32'h0000_0001);
    endtask

    task t_mf;
        logic [31:0] cf [6] = '{32'h301, 32'h302, 32'h701, 32'h101, 32'h201, 32'h303};
        logic        ex [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        wr_reg(8'h14, 32'h0000_0301);
        check("pending", 32'(mfa), 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h14, cf[i]);
            wr_reg(8'h34, 32'h0000_0001);
            rd_reg(8'h38, v);
            check("mf_active", 32'(mfa), 32'(ex[i]));
            check("status", v & 32'h43, (cf[i] & 32'h3) | (32'(ex[i]) << 6));
        end
        reset <= 1;
        repeat (2) @(posedge core_clk);
        #1 check("rst_trq", 32'(tout), 32'h0);
        check("rst_mf", 32'(mfa), 32'h0);
    endtask

    initial begin
        reset = 1; wr = 0; rd = 0; addr = '0; wdata = '0; pref = '0; isff = '0;
        itff = '0; tref = '0; spd_set = '0; load = '0;
        repeat (16) @(posedge core_clk);
        reset <= 0;
        t_regs();
        t_fric();
        t_ff();
        t_model();
        t_mf();
        results();
    end
endmodule
